// File: verilog/servo_sup_defs.svh
`ifndef SERVO_SUP_DEFS_SVH
`define SERVO_SUP_DEFS_SVH
// Register byte offsets
`define OFS_CTRL     12'h000
`define OFS_CFG      12'h004
`define OFS_MODE_REQ 12'h008
`define OFS_STATUS   12'h00c
`define OFS_LIVE_SEL 12'h010
`define OFS_LIVE_RES 12'h014
`define OFS_ARG0     12'h018
`define OFS_ARG6     12'h030
`define OFS_ARR_BAND 12'h034
`define OFS_ARR_DWEL 12'h038
`define OFS_FLT_BAND 12'h03c
`define OFS_WRN_BAND 12'h040
`define OFS_TRK_TOUT 12'h044
`define OFS_DECEL    12'h048
// Control word fields
`define CW_QSTOP 2
`define CW_BIT4  4
`define CW_HALT  8
// Mode codes
`define MODE_PP  8'h01
`define MODE_HM  8'h06
`define MODE_IP  8'h07
`define MODE_CSP 8'h08
`define MODE_CPV 8'hfd
// Live-mode result codes
`define LIVE_OK  8'h00
`define LIVE_BAD 8'h01
// Control cycle timing
`define CTRL_CYCLE_NS 50000
`define CLK_NS        25
`define CTRL_CYCLES   ((`CTRL_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: verilog/servo_sup_pkg.sv
`default_nettype none
package servo_sup_pkg;
  // Drive state machine states, one-hot
  typedef enum logic [7:0] {
    ST_NRTSO = 8'h01,
    ST_SOD   = 8'h02,
    ST_RTSO  = 8'h04,
    ST_SO    = 8'h08,
    ST_OE    = 8'h10,
    ST_QSA   = 8'h20,
    ST_FRA   = 8'h40,
    ST_FLT   = 8'h80
  } drive_state_e;
  // Stop supervisor states, one-hot
  typedef enum logic [3:0] {
    SP_RUN   = 4'h1,
    SP_HALT  = 4'h2,
    SP_QSTOP = 4'h4,
    SP_BRAKE = 4'h8
  } stop_e;
endpackage
`default_nettype wire

// File: verilog/servo_enable_mode_supervisor.sv
// Overview of operation
// - Drive enabled in Operation enable, or Switched On with option 1.
// - Never enabled unless enable input level is 1.
// - Switched On with option 0, or Switch On Disabled, disables drive.
// - Option 1 and Switched On stops motion only, drive stays enabled.
// - Disable while moving in Operation enable zeroes speed, brakes hard.
// - Stop commands accepted only in Operation enable, reported in status.
// - Halt ramps at profile decel from commanded values, keeps tracking errors.
// - Quick stop ramps per config from measured velocity, clears speed error.
// - Mode request takes effect on write; indicator shows mode in force.
// - In Operation enable, mode request accepted only with bit 4 at 0.
// - Mode request rejected in Not Ready, Quick Stop Active, Fault Reaction.
// - Live change among four modes, motor runs, stays in Operation enable.
// - Live change accepted only from auxiliary Modbus port writes.
// - Live select, live result and seven mode-dependent argument slots.
// - Argument slot writes obey restrictions of aliased parameters.
// - Live entry to profile position runs absolute single set-point moves.
// - Target reached after gap below band for dwell; clears above band.
// - Following fault or warning after error over band for timeout.
// - Following status bit set after timeout outside homing, cleared below fault band.
`timescale 1ns/100ps
`default_nettype none
`include "servo_sup_defs.svh"
module servo_enable_mode_supervisor (
  input  wire logic                       pclk,          // Clock 40 MHz
  input  wire logic                       presetn,       // Async reset, low
  input  wire logic                       psel,          // APB select
  input  wire logic                       penable,       // APB enable
  input  wire logic                       pwrite,        // APB direction
  input  wire logic [11:0]                paddr,         // APB byte address
  input  wire logic [31:0]                pwdata,        // APB write data
  output logic                            pready,        // APB ready
  output logic [31:0]                     prdata,        // APB read data
  output logic                            pslverr,       // APB error
  input  wire logic                       aux_src,       // Access from Modbus
  input  wire servo_sup_pkg::drive_state_e sm_state,     // Drive state
  input  wire logic                       enable_input_level, // Enable input
  input  wire logic                       motor_moving,  // Motor in motion
  input  wire logic signed [31:0]         measured_position, // Actual position
  input  wire logic signed [31:0]         commanded_position, // Demand position
  input  wire logic signed [31:0]         measured_velocity, // Actual speed
  input  wire logic signed [31:0]         commanded_speed_in, // Demand speed
  input  wire logic signed [31:0]         position_tracking_error, // Pos error
  output logic                            drive_enabled, // Drive enabled
  output logic                            motion_enabled, // Motion allowed
  output logic                            speed_zero,    // Force speed 0
  output logic                            brake_max,     // Max deceleration
  output logic                            ramp_active,   // Stop ramp running
  output logic [31:0]                     ramp_decel,    // Ramp deceleration
  output logic [2:0]                      ramp_cfg,      // Quick stop config
  output logic signed [31:0]              ramp_start_speed, // Ramp start speed
  output logic                            ramp_from_cmd_pos, // Halt from demand
  output logic                            speed_err_clr, // Clear speed error
  output logic [7:0]                      active_mode_indicator, // Mode in force
  output logic                            live_apply,    // Live change pulse
  output logic                            pp_abs_single, // Absolute single
  output logic                            target_reached, // Arrival status
  output logic                            fe_status,     // Following status
  output logic                            fe_fault,      // Following fault
  output logic                            fe_warn        // Following warning
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0]        ctrl_r;
  logic               sw_on_opt_r;
  logic [2:0]         qcfg_r;
  logic [7:0]         live_res_r;
  logic [7:0]         live_sel_r;
  logic [31:0]        args_r [0:6];
  logic [31:0]        arr_band_r;
  logic [15:0]        arr_dwell_r;
  logic [31:0]        flt_band_r;
  logic [31:0]        wrn_band_r;
  logic [15:0]        tout_r;
  logic [31:0]        decel_r;
  servo_sup_pkg::stop_e stop_r;
  logic               oe_d_r;
  logic [10:0]        div_r;
  logic               tick_r;
  logic [15:0]        arr_cnt_r;
  logic [15:0]        flt_cnt_r;
  logic [15:0]        wrn_cnt_r;
  logic [31:0]        rdata;
  logic               mapped;
  logic               wr_en;
  logic               in_oe;
  logic               pos_mode;
  logic               live_ok;
  logic [31:0]        pos_gap;
  logic [31:0]        err_abs;

  assign in_oe = (sm_state == servo_sup_pkg::ST_OE);
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // ****************************************
  // APB slave
  // ****************************************
  // Address decode and read mux
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_CTRL:     rdata = {16'h0000, ctrl_r};
      `OFS_CFG:      rdata = {28'h0000000, qcfg_r, sw_on_opt_r};
      `OFS_MODE_REQ: rdata = {24'h000000, active_mode_indicator};
      `OFS_STATUS:   rdata = {16'h0000, active_mode_indicator, fe_warn, fe_fault,
                              fe_status, target_reached, stop_r[2], stop_r[1],
                              motion_enabled, drive_enabled};
      `OFS_LIVE_SEL: rdata = {24'h000000, live_sel_r};
      `OFS_LIVE_RES: rdata = {24'h000000, live_res_r};
      `OFS_ARR_BAND: rdata = arr_band_r;
      `OFS_ARR_DWEL: rdata = {16'h0000, arr_dwell_r};
      `OFS_FLT_BAND: rdata = flt_band_r;
      `OFS_WRN_BAND: rdata = wrn_band_r;
      `OFS_TRK_TOUT: rdata = {16'h0000, tout_r};
      `OFS_DECEL:    rdata = decel_r;
      default: begin
        if (paddr >= `OFS_ARG0 && paddr <= `OFS_ARG6 && paddr[1:0] == 2'b00) begin
          rdata = args_r[3'((paddr - `OFS_ARG0) >> 2)];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // One wait-free access phase, answer registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control word and parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= 16'h0000;
      sw_on_opt_r <= 1'b0;
      qcfg_r      <= 3'h0;
      arr_band_r  <= 32'h0000_0000;
      arr_dwell_r <= 16'h0000;
      flt_band_r  <= 32'hffff_ffff;
      wrn_band_r  <= 32'hffff_ffff;
      tout_r      <= 16'h0000;
      decel_r     <= 32'h0000_0000;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL:     ctrl_r      <= pwdata[15:0];
        `OFS_CFG: begin
          sw_on_opt_r <= pwdata[0];
          qcfg_r      <= pwdata[3:1];
        end
        `OFS_ARR_BAND: arr_band_r  <= pwdata;
        `OFS_ARR_DWEL: arr_dwell_r <= pwdata[15:0];
        `OFS_FLT_BAND: flt_band_r  <= pwdata;
        `OFS_WRN_BAND: wrn_band_r  <= pwdata;
        `OFS_TRK_TOUT: tout_r      <= pwdata[15:0];
        `OFS_DECEL:    decel_r     <= pwdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Enable and disable
  // ****************************************
  // Enabled state from drive state, option and enable input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enabled  <= 1'b0;
      motion_enabled <= 1'b0;
    end else begin
      drive_enabled  <= enable_input_level &
                        (in_oe | (sm_state == servo_sup_pkg::ST_SO && sw_on_opt_r));
      motion_enabled <= enable_input_level & in_oe & (stop_r == servo_sup_pkg::SP_RUN);
    end
  end

  a_en_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(enable_input_level) |-> !drive_enabled)
    else $error("drive enabled without enable input");
  a_so_opt: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sm_state == servo_sup_pkg::ST_SO) && $past(enable_input_level)
    |-> drive_enabled == $past(sw_on_opt_r) && !motion_enabled)
    else $error("switched on option handled wrongly");

  // ****************************************
  // Stop supervisor
  // ****************************************
  // Halt, quick stop and disable braking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r <= servo_sup_pkg::SP_RUN;
      oe_d_r <= 1'b0;
    end else begin
      oe_d_r <= in_oe;
      unique case (stop_r)
        servo_sup_pkg::SP_RUN: begin
          if (oe_d_r && !in_oe && motor_moving) begin
            stop_r <= servo_sup_pkg::SP_BRAKE;
          end else if (in_oe && ctrl_r[`CW_QSTOP]) begin
            stop_r <= servo_sup_pkg::SP_QSTOP;
          end else if (in_oe && ctrl_r[`CW_HALT]) begin
            stop_r <= servo_sup_pkg::SP_HALT;
          end
        end
        servo_sup_pkg::SP_HALT, servo_sup_pkg::SP_QSTOP: begin
          if (!in_oe && motor_moving) begin
            stop_r <= servo_sup_pkg::SP_BRAKE;
          end else if (!in_oe) begin
            stop_r <= servo_sup_pkg::SP_RUN;
          end else if (stop_r == servo_sup_pkg::SP_HALT && ctrl_r[`CW_QSTOP]) begin
            stop_r <= servo_sup_pkg::SP_QSTOP;
          end else if (!ctrl_r[`CW_HALT] && !ctrl_r[`CW_QSTOP]) begin
            stop_r <= servo_sup_pkg::SP_RUN;
          end
        end
        servo_sup_pkg::SP_BRAKE: begin
          if (!motor_moving) begin
            stop_r <= servo_sup_pkg::SP_RUN;
          end
        end
        default: stop_r <= servo_sup_pkg::SP_RUN;
      endcase
    end
  end

  // Ramp outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_zero        <= 1'b0;
      brake_max         <= 1'b0;
      ramp_active       <= 1'b0;
      ramp_decel        <= 32'h0000_0000;
      ramp_cfg          <= 3'h0;
      ramp_start_speed  <= 32'sh0000_0000;
      ramp_from_cmd_pos <= 1'b0;
      speed_err_clr     <= 1'b0;
    end else begin
      speed_zero    <= (stop_r == servo_sup_pkg::SP_BRAKE);
      brake_max     <= (stop_r == servo_sup_pkg::SP_BRAKE);
      ramp_active   <= (stop_r == servo_sup_pkg::SP_HALT) |
                       (stop_r == servo_sup_pkg::SP_QSTOP);
      ramp_cfg      <= qcfg_r;
      speed_err_clr <= 1'b0;
      if (stop_r == servo_sup_pkg::SP_RUN && in_oe && ctrl_r[`CW_HALT] &&
          !ctrl_r[`CW_QSTOP]) begin
        ramp_decel        <= decel_r;
        ramp_start_speed  <= commanded_speed_in;
        ramp_from_cmd_pos <= 1'b1;
      end
      if (stop_r != servo_sup_pkg::SP_QSTOP && in_oe && ctrl_r[`CW_QSTOP] &&
          (stop_r == servo_sup_pkg::SP_RUN || stop_r == servo_sup_pkg::SP_HALT)) begin
        ramp_start_speed  <= measured_velocity;
        ramp_from_cmd_pos <= 1'b0;
        speed_err_clr     <= 1'b1;
      end
    end
  end

  a_brake_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $past(in_oe) && !in_oe && motor_moving && stop_r == servo_sup_pkg::SP_RUN
    |=> ##1 speed_zero && brake_max)
    else $error("no hard brake on disable");
  a_stop_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !in_oe && $stable(sm_state) && !motor_moving |=> ##1 !ramp_active)
    else $error("stop ramp outside operation enable");
  a_qs_clr: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stop_r == servo_sup_pkg::SP_QSTOP) |-> speed_err_clr && !ramp_from_cmd_pos)
    else $error("quick stop did not clear speed error");

  // ****************************************
  // Mode change
  // ****************************************
  // Live change allowed codes and source
  assign live_ok = aux_src & in_oe &
                   (pwdata[7:0] == `MODE_PP || pwdata[7:0] == `MODE_HM ||
                    pwdata[7:0] == `MODE_IP || pwdata[7:0] == `MODE_CPV);

  // Mode request, live select and result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode_indicator <= 8'h00;
      live_sel_r            <= 8'h00;
      live_res_r            <= `LIVE_OK;
      live_apply            <= 1'b0;
      pp_abs_single         <= 1'b0;
    end else begin
      live_apply <= 1'b0;
      if (wr_en && paddr == `OFS_MODE_REQ &&
          !(in_oe && ctrl_r[`CW_BIT4]) &&
          sm_state != servo_sup_pkg::ST_NRTSO &&
          sm_state != servo_sup_pkg::ST_QSA &&
          sm_state != servo_sup_pkg::ST_FRA) begin
        active_mode_indicator <= pwdata[7:0];
        pp_abs_single         <= 1'b0;
      end
      if (wr_en && paddr == `OFS_LIVE_SEL) begin
        live_sel_r <= pwdata[7:0];
        if (live_ok) begin
          active_mode_indicator <= pwdata[7:0];
          live_res_r            <= `LIVE_OK;
          live_apply            <= 1'b1;
          pp_abs_single         <= (pwdata[7:0] == `MODE_PP);
        end else begin
          live_res_r <= `LIVE_BAD;
        end
      end
    end
  end

  // Argument slots, same restrictions as aliased parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 7; i++) begin
        args_r[i] <= 32'h0000_0000;
      end
    end else if (wr_en && aux_src && paddr >= `OFS_ARG0 && paddr <= `OFS_ARG6 &&
                 sm_state != servo_sup_pkg::ST_FRA) begin
      args_r[3'((paddr - `OFS_ARG0) >> 2)] <= pwdata;
    end
  end

  a_bit4_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `OFS_MODE_REQ && in_oe && ctrl_r[`CW_BIT4]
    |=> $stable(active_mode_indicator))
    else $error("mode changed with bit 4 set");
  a_mode_rej: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `OFS_MODE_REQ && sm_state == servo_sup_pkg::ST_QSA
    |=> $stable(active_mode_indicator))
    else $error("mode changed in forbidden state");
  a_live_src: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `OFS_LIVE_SEL && !aux_src
    |=> live_res_r == `LIVE_BAD && !live_apply)
    else $error("live change accepted off Modbus");

  // ****************************************
  // Position monitoring
  // ****************************************
  // Control cycle tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 11'(`CTRL_CYCLES - 1));
      div_r  <= (div_r == 11'(`CTRL_CYCLES - 1)) ? 11'h000 : div_r + 11'h001;
    end
  end

  assign pos_mode = (active_mode_indicator == `MODE_PP) ||
                    (active_mode_indicator == `MODE_HM) ||
                    (active_mode_indicator == `MODE_IP) ||
                    (active_mode_indicator == `MODE_CSP);
  assign pos_gap  = (measured_position >= commanded_position) ?
                    32'(measured_position - commanded_position) :
                    32'(commanded_position - measured_position);
  assign err_abs  = position_tracking_error[31] ?
                    32'(-position_tracking_error) : 32'(position_tracking_error);

  // Dwell counters, saturating, restart on false condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_cnt_r <= 16'h0000;
      flt_cnt_r <= 16'h0000;
      wrn_cnt_r <= 16'h0000;
    end else if (tick_r) begin
      arr_cnt_r <= (pos_mode && pos_gap < arr_band_r) ?
                   ((&arr_cnt_r) ? arr_cnt_r : arr_cnt_r + 16'h0001) : 16'h0000;
      flt_cnt_r <= (pos_mode && err_abs > flt_band_r) ?
                   ((&flt_cnt_r) ? flt_cnt_r : flt_cnt_r + 16'h0001) : 16'h0000;
      wrn_cnt_r <= (pos_mode && err_abs > wrn_band_r) ?
                   ((&wrn_cnt_r) ? wrn_cnt_r : wrn_cnt_r + 16'h0001) : 16'h0000;
    end
  end

  // Target reached and following error flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reached <= 1'b0;
      fe_status      <= 1'b0;
      fe_fault       <= 1'b0;
      fe_warn        <= 1'b0;
    end else if (!pos_mode) begin
      target_reached <= 1'b0;
      fe_status      <= 1'b0;
      fe_fault       <= 1'b0;
      fe_warn        <= 1'b0;
    end else begin
      // arrival band and dwell, leaving the band wins over a stale count
      if (pos_gap > arr_band_r) begin
        target_reached <= 1'b0;
      end else if (arr_cnt_r >= arr_dwell_r && arr_cnt_r != 16'h0000) begin
        target_reached <= 1'b1;
      end
      fe_fault <= (flt_cnt_r >= tout_r && flt_cnt_r != 16'h0000);
      fe_warn  <= (wrn_cnt_r >= tout_r && wrn_cnt_r != 16'h0000);
      // status bit in position modes except homing, clear below band wins over a stale count
      if (err_abs < flt_band_r) begin
        fe_status <= 1'b0;
      end else if (flt_cnt_r >= tout_r && flt_cnt_r != 16'h0000 &&
                   active_mode_indicator != `MODE_HM) begin
        fe_status <= 1'b1;
      end
    end
  end

  a_tgt_clr: assert property (@(posedge pclk) disable iff (!presetn)
    pos_mode && pos_gap > arr_band_r |=> !target_reached)
    else $error("target reached kept outside band");
  a_fe_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pos_mode && err_abs < flt_band_r |=> !fe_status)
    else $error("following status not cleared");
  a_cnt_rst: assert property (@(posedge pclk) disable iff (!presetn)
    tick_r && !(pos_mode && err_abs > flt_band_r) |=> flt_cnt_r == 16'h0000)
    else $error("timeout counter not restarted");

endmodule
`default_nettype wire

// File: dv/apb_master_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "servo_sup_defs.svh"
// ****************************************
// APB side of the fieldbus master
// ****************************************
module apb_master_model (
  input  wire logic        pclk,    // Clock
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic [11:0]      paddr,   // Byte address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic        pready,  // Ready
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pslverr  // Error
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic live_change(input logic [7:0] m, output logic [31:0] r);
    logic e;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, `OFS_ARG0 + 12'(4 * i), 32'(i + 1), r, e);
    end
    xfer(1'b1, `OFS_LIVE_SEL, {24'h0, m}, r, e);
    xfer(1'b0, `OFS_LIVE_RES, 32'h0, r, e);
  endtask
endmodule
`default_nettype wire

// File: dv/servo_enable_mode_supervisor_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "servo_sup_defs.svh"
// ****************************************
// Supervisor bench
// ****************************************
module servo_enable_mode_supervisor_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic aux_src, enable_input_level, motor_moving;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic signed [31:0] measured_position;
  logic drive_enabled, motion_enabled, speed_zero, ramp_active, ramp_from_cmd_pos, target_reached;
  logic [7:0] active_mode_indicator;
  servo_sup_pkg::drive_state_e sm_state;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  apb_master_model u_apb_master_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr);
  servo_enable_mode_supervisor u_servo_enable_mode_supervisor (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .aux_src, .sm_state, .enable_input_level, .motor_moving, .measured_position,
    .commanded_position(32'sh0), .measured_velocity(32'sh0), .commanded_speed_in(32'sh0),
    .position_tracking_error(32'sh0), .drive_enabled, .motion_enabled, .speed_zero,
    .brake_max(), .ramp_active, .ramp_decel(), .ramp_cfg(), .ramp_start_speed(),
    .ramp_from_cmd_pos, .speed_err_clr(), .active_mode_indicator, .live_apply(),
    .pp_abs_single(), .target_reached, .fe_status(), .fe_fault(), .fe_warn());
  // Clock and hang limit
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      err_count++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_apb_master_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a);
    u_apb_master_model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task t_enable;
    rd(`OFS_STATUS);
    chk(q, 32'h0);
    rd(12'hffc);
    chk(e, 1'b1);
    wr(`OFS_CFG, 32'h0);
    sm_state <= servo_sup_pkg::ST_OE;
    settle();
    chk(drive_enabled, 1'b1);
    @(posedge pclk);
    enable_input_level <= 1'b0;
    settle();
    chk(drive_enabled, 1'b0);
    @(posedge pclk);
    enable_input_level <= 1'b1;
    sm_state <= servo_sup_pkg::ST_SO;
    settle();
    chk({drive_enabled, motion_enabled}, 2'b00);
    wr(`OFS_CFG, 32'h1);
    settle();
    chk({drive_enabled, motion_enabled}, 2'b10);
    @(posedge pclk);
    sm_state <= servo_sup_pkg::ST_OE;
    motor_moving <= 1'b1;
    settle();
    @(posedge pclk);
    sm_state <= servo_sup_pkg::ST_SOD;
    settle();
    chk({speed_zero, drive_enabled}, 2'b10);
  endtask
  task t_mode;
    @(posedge pclk);
    motor_moving <= 1'b0;
    sm_state <= servo_sup_pkg::ST_OE;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_MODE_REQ, `MODE_PP);
    settle();
    chk(active_mode_indicator, `MODE_PP);
    wr(`OFS_CTRL, 32'h10);
    wr(`OFS_MODE_REQ, `MODE_HM);
    rd(`OFS_MODE_REQ);
    chk(q, `MODE_PP);
    wr(`OFS_CTRL, 32'h0);
    sm_state <= servo_sup_pkg::ST_QSA;
    wr(`OFS_MODE_REQ, `MODE_HM);
    settle();
    chk(active_mode_indicator, `MODE_PP);
  endtask
  task t_live;
    @(posedge pclk);
    sm_state <= servo_sup_pkg::ST_OE;
    motor_moving <= 1'b1;
    wr(`OFS_LIVE_SEL, `MODE_HM);
    rd(`OFS_LIVE_RES);
    chk(q, `LIVE_BAD);
    aux_src <= 1'b1;
    u_apb_master_model.live_change(`MODE_HM, q);
    chk(q, `LIVE_OK);
    settle();
    chk({active_mode_indicator, drive_enabled}, {`MODE_HM, 1'b1});
  endtask
  task t_stop;
    @(posedge pclk);
    motor_moving <= 1'b0;
    sm_state <= servo_sup_pkg::ST_SO;
    wr(`OFS_CTRL, 32'h100);
    settle();
    chk(ramp_active, 1'b0);
    @(posedge pclk);
    sm_state <= servo_sup_pkg::ST_OE;
    settle();
    chk({ramp_active, ramp_from_cmd_pos}, 2'b11);
    wr(`OFS_CTRL, 32'h104);
    settle();
    chk({ramp_active, ramp_from_cmd_pos}, 2'b10);
    wr(`OFS_CTRL, 32'h0);
  endtask
  task t_arrive;
    measured_position <= 32'sd100;
    wr(`OFS_ARR_BAND, 32'd10);
    wr(`OFS_ARR_DWEL, 32'd2);
    repeat (2100) @(posedge pclk);
    measured_position <= 32'sd5;
    repeat (1900) @(posedge pclk);
    @(negedge pclk);
    chk(target_reached, 1'b0);
    repeat (4300) @(posedge pclk);
    @(negedge pclk);
    chk(target_reached, 1'b1);
    @(posedge pclk);
    measured_position <= -32'sd11;
    settle();
    chk(target_reached, 1'b0);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    aux_src = 1'b0;
    enable_input_level = 1'b1;
    motor_moving = 1'b0;
    measured_position = 32'sh0;
    sm_state = servo_sup_pkg::ST_SOD;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_enable();
    t_mode();
    t_live();
    t_stop();
    t_arrive();
    finish_test();
  end
endmodule
`default_nettype wire
